// file: plc_pkg.sv
// Package: register map, field layouts and constants of the clock control
package plc_pkg;

  // ==========================================================
  // Register offsets (byte addresses), gating pages (address bits 11:4) and gating register count
  localparam logic [11:0] OFS_RAW_INT_STATUS = 12'h050;
  localparam logic [11:0] OFS_INT_MASK = 12'h054;
  localparam logic [11:0] OFS_RUN_CFG = 12'h060;
  localparam logic [11:0] OFS_PLL_XLAT = 12'h064;
  localparam logic [11:0] OFS_RUN_CFG_EXT = 12'h070;
  localparam logic [11:0] OFS_DS_CLK_CFG = 12'h144;
  localparam logic [7:0] PAGE_RUN_GATE = 8'h10;
  localparam logic [7:0] PAGE_SLEEP_GATE = 8'h11;
  localparam logic [7:0] PAGE_DS_GATE = 8'h12;
  localparam int GATE_REGS = 3;

  // ==========================================================
  // Reset values and writable masks
  localparam logic [31:0] RUN_CFG_RST = 32'h0000_2810;
  localparam logic [31:0] RUN_CFG_MASK = 32'h0FC0_2FF0;
  localparam logic [31:0] RUN_CFG_EXT_RST = 32'h0000_2810;
  localparam logic [31:0] RUN_CFG_EXT_MASK = 32'h9F80_2830;
  localparam logic [31:0] DS_CLK_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] DS_CLK_CFG_MASK = 32'h0000_0030;
  localparam logic [31:0] GATE_RST = 32'h0000_0000;
  localparam logic [31:0] XLAT_RST = 32'h0000_0000;

  // ==========================================================
  // Relock, crystal translation and deep-sleep divider figures
  localparam logic [12:0] RELOCK_LOAD = 13'h1200;
  localparam logic [13:0] XLAT_F_BASE = 14'h00C8;
  localparam logic [5:0] DS_DIV_BASE = 6'h0F;
  localparam logic [5:0] DS_DIV_EXT = 6'h3F;

  // ==========================================================
  // Oscillator source codes
  localparam logic [1:0] SRC_MAIN = 2'h0;
  localparam logic [1:0] SRC_INT = 2'h1;
  localparam logic [1:0] SRC_INT_DIV4 = 2'h2;
  localparam logic [1:0] SRC_INT_30K = 2'h3;

  // ==========================================================
  // Field layouts
  typedef struct packed {
    logic [3:0] rsv3;
    logic auto_gate;
    logic [3:0] system_divider;
    logic use_divider;
    logic [7:0] rsv2;
    logic pll_power_down_bit;
    logic rsv1;
    logic bypass;
    logic [4:0] crystal_number;
    logic [1:0] oscillator_source;
    logic [3:0] rsv0;
  } plc_run_cfg_t;

  typedef struct packed {
    logic ext_config_select;
    logic [1:0] rsv3;
    logic [5:0] system_divider;
    logic [8:0] rsv2;
    logic pll_power_down_bit;
    logic rsv1;
    logic bypass;
    logic [4:0] rsv0b;
    logic [1:0] oscillator_source;
    logic [3:0] rsv0;
  } plc_run_cfg_ext_t;

  typedef struct packed {
    logic [1:0] oscillator_source;
    logic use_pll;
    logic use_divider;
    logic [5:0] system_divider;
  } plc_clk_sel_t;

  typedef enum logic [3:0] {
    PM_RUN = 4'h1,
    PM_SLEEP = 4'h2,
    PM_DEEP = 4'h4,
    PM_RESTORE = 4'h8
  } plc_pm_state_t;

endpackage

// file: plc_clock_ctrl.sv
// Clock control: PLL relock, power modes and peripheral clock gating

module plc_clock_ctrl #(
  parameter logic [12:0] RELOCK_COUNT = plc_pkg::RELOCK_LOAD
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Processor core
  input wire logic i_wait_for_interrupt_instr,
  input wire logic i_deep_sleep_en,
  input wire logic i_wake_irq,
  // Main oscillator pin
  input wire logic i_main_oscillator,
  // Clock tree controls
  output plc_pkg::plc_clk_sel_t o_clk_sel,
  output logic o_core_clk_en,
  output logic o_mem_clk_en,
  output logic [95:0] o_periph_clk_en,
  output logic o_pll_pwr_en,
  output logic [31:0] o_pll_translation,
  output logic o_main_osc_en,
  output logic o_int_osc_en,
  output logic o_pll_lock_irq
);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xlat(input logic [4:0] crystal);
    logic [13:0] f;
    f = plc_pkg::XLAT_F_BASE - {9'h000, crystal};
    xlat = {13'h0000, crystal[4:0], f};
  endfunction

  function automatic logic gate_hit(input logic [11:0] a,
                                    input logic [7:0] page);
    gate_hit = (a[11:4] == page) && (a[3:2] < 2'h3) && (a[1:0] == 2'h0);
  endfunction

  // ==========================================================
  // Registers
  plc_pkg::plc_run_cfg_t run_clock_config;
  plc_pkg::plc_run_cfg_ext_t run_clock_config_ext;
  logic [31:0] deep_sleep_clock_config;
  logic [31:0] run_gating_set [plc_pkg::GATE_REGS];
  logic [31:0] sleep_gating_set [plc_pkg::GATE_REGS];
  logic [31:0] deep_sleep_gating_set [plc_pkg::GATE_REGS];
  logic [31:0] pll_translation_reg;
  logic lock_int_mask;
  logic pll_lock_raw_flag;
  logic [4:0] prev_crystal;
  logic prev_pll_on;
  logic [12:0] relock_cnt;
  logic osc_meta;
  logic osc_sync;
  logic osc_prev;
  logic was_pll;
  plc_pkg::plc_pm_state_t state;
  plc_pkg::plc_pm_state_t next_state;

  logic ext_sel;
  logic eff_bypass;
  logic eff_pd;
  logic [1:0] eff_src;
  logic [5:0] eff_div;
  logic pll_on;
  logic relock_trig;
  logic use_pll;
  logic osc_tick;
  logic [1:0] ds_src;
  logic [1:0] gidx;
  plc_pkg::plc_clk_sel_t run_sel;
  plc_pkg::plc_clk_sel_t next_sel;
  logic [95:0] next_gate;

  assign gidx = i_addr[3:2];

  // ==========================================================
  // Effective configuration
  assign ext_sel = run_clock_config_ext.ext_config_select;
  assign eff_bypass = ext_sel ? run_clock_config_ext.bypass
                              : run_clock_config.bypass;
  assign eff_pd = ext_sel ? run_clock_config_ext.pll_power_down_bit
                          : run_clock_config.pll_power_down_bit;
  assign eff_src = ext_sel ? run_clock_config_ext.oscillator_source
                           : run_clock_config.oscillator_source;
  assign eff_div = ext_sel ? run_clock_config_ext.system_divider
                           : {2'h0, run_clock_config.system_divider};
  assign ds_src = deep_sleep_clock_config[5:4];

  // Deep-sleep overrides power on a PLL that was in use
  assign pll_on = !eff_pd && !(state == plc_pkg::PM_DEEP && was_pll);
  assign relock_trig = (run_clock_config.crystal_number != prev_crystal)
                       || (pll_on && !prev_pll_on);
  assign use_pll = !eff_bypass && pll_on && pll_lock_raw_flag;
  assign osc_tick = osc_sync && !osc_prev;

  // ==========================================================
  // Register writes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      run_clock_config <= plc_pkg::RUN_CFG_RST;
      run_clock_config_ext <= plc_pkg::RUN_CFG_EXT_RST;
      deep_sleep_clock_config <= plc_pkg::DS_CLK_CFG_RST;
      lock_int_mask <= 1'b0;
    end else if (i_wr) begin
      case (i_addr)
        plc_pkg::OFS_RUN_CFG: begin
          run_clock_config <= i_wdata & plc_pkg::RUN_CFG_MASK;
        end
        plc_pkg::OFS_RUN_CFG_EXT: begin
          run_clock_config_ext <= i_wdata & plc_pkg::RUN_CFG_EXT_MASK;
        end
        plc_pkg::OFS_DS_CLK_CFG: begin
          deep_sleep_clock_config <= i_wdata & plc_pkg::DS_CLK_CFG_MASK;
        end
        plc_pkg::OFS_INT_MASK: begin
          lock_int_mask <= i_wdata[0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < plc_pkg::GATE_REGS; k++) begin
        run_gating_set[k] <= plc_pkg::GATE_RST;
        sleep_gating_set[k] <= plc_pkg::GATE_RST;
        deep_sleep_gating_set[k] <= plc_pkg::GATE_RST;
      end
    end else if (i_wr) begin
      if (gate_hit(i_addr, plc_pkg::PAGE_RUN_GATE)) begin
        run_gating_set[gidx] <= i_wdata;
      end
      if (gate_hit(i_addr, plc_pkg::PAGE_SLEEP_GATE)) begin
        sleep_gating_set[gidx] <= i_wdata;
      end
      if (gate_hit(i_addr, plc_pkg::PAGE_DS_GATE)) begin
        deep_sleep_gating_set[gidx] <= i_wdata;
      end
    end
  end

  // ==========================================================
  // Register reads, data one cycle after the strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      if (gate_hit(i_addr, plc_pkg::PAGE_RUN_GATE)) begin
        o_rdata <= run_gating_set[gidx];
      end else if (gate_hit(i_addr, plc_pkg::PAGE_SLEEP_GATE)) begin
        o_rdata <= sleep_gating_set[gidx];
      end else if (gate_hit(i_addr, plc_pkg::PAGE_DS_GATE)) begin
        o_rdata <= deep_sleep_gating_set[gidx];
      end else begin
        case (i_addr)
          plc_pkg::OFS_RUN_CFG: o_rdata <= run_clock_config;
          plc_pkg::OFS_RUN_CFG_EXT: o_rdata <= run_clock_config_ext;
          plc_pkg::OFS_DS_CLK_CFG: o_rdata <= deep_sleep_clock_config;
          plc_pkg::OFS_PLL_XLAT: o_rdata <= pll_translation_reg;
          plc_pkg::OFS_INT_MASK: o_rdata <= {31'h0, lock_int_mask};
          plc_pkg::OFS_RAW_INT_STATUS: begin
            o_rdata <= {31'h0, pll_lock_raw_flag};
          end
          default: o_rdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Crystal translation
  // Only a real value change retranslates, not a rewrite
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pll_translation_reg <= plc_pkg::XLAT_RST;
      prev_crystal <= plc_pkg::RUN_CFG_RST[10:6];
      prev_pll_on <= 1'b0;
    end else begin
      pll_translation_reg <= xlat(run_clock_config.crystal_number);
      prev_crystal <= run_clock_config.crystal_number;
      prev_pll_on <= pll_on;
    end
  end

  // ==========================================================
  // Main oscillator sampling
  // Two flops first: the pin is unrelated to i_clk
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_meta <= i_main_oscillator;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end

  // ==========================================================
  // Relock counter and lock flag
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      relock_cnt <= 13'h0000;
    end else if (relock_trig) begin
      relock_cnt <= RELOCK_COUNT;
    end else if (pll_on && osc_tick && relock_cnt != 13'h0000) begin
      relock_cnt <= relock_cnt - 13'h0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pll_lock_raw_flag <= 1'b0;
    end else if (relock_trig || !pll_on) begin
      pll_lock_raw_flag <= 1'b0;
    end else if (relock_cnt == 13'h0000) begin
      pll_lock_raw_flag <= 1'b1;
    end
  end

  // ==========================================================
  // Power mode sequencing
  always_comb begin
    next_state = state;
    case (state)
      plc_pkg::PM_RUN: begin
        if (i_wait_for_interrupt_instr) begin
          next_state = i_deep_sleep_en ? plc_pkg::PM_DEEP
                                       : plc_pkg::PM_SLEEP;
        end
      end
      plc_pkg::PM_SLEEP: begin
        if (i_wake_irq) begin
          next_state = plc_pkg::PM_RUN;
        end
      end
      plc_pkg::PM_DEEP: begin
        if (i_wake_irq) begin
          next_state = plc_pkg::PM_RESTORE;
        end
      end
      plc_pkg::PM_RESTORE: begin
        // Hold clocks off until the entry clock is back
        if (!was_pll || use_pll) begin
          next_state = plc_pkg::PM_RUN;
        end
      end
      default: next_state = plc_pkg::PM_RUN;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= plc_pkg::PM_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      was_pll <= 1'b0;
    end else if (state == plc_pkg::PM_RUN && next_state == plc_pkg::PM_DEEP) begin
      was_pll <= use_pll;
    end else if (state == plc_pkg::PM_RESTORE && next_state == plc_pkg::PM_RUN) begin
      was_pll <= 1'b0;
    end
  end

  // ==========================================================
  // Clock selection and gating
  always_comb begin
    run_sel.oscillator_source = eff_src;
    run_sel.use_pll = use_pll;
    run_sel.use_divider = run_clock_config.use_divider && !eff_bypass;
    run_sel.system_divider = eff_div;
    next_sel = run_sel;
    next_gate = {run_gating_set[2], run_gating_set[1], run_gating_set[0]};
    case (state)
      plc_pkg::PM_SLEEP: begin
        if (run_clock_config.auto_gate) begin
          next_gate = {sleep_gating_set[2], sleep_gating_set[1],
                       sleep_gating_set[0]};
        end
      end
      plc_pkg::PM_DEEP: begin
        next_sel.oscillator_source = ds_src;
        next_sel.use_pll = 1'b0;
        if (was_pll) begin
          next_sel.use_divider = 1'b1;
          next_sel.system_divider = ext_sel ? plc_pkg::DS_DIV_EXT
                                            : plc_pkg::DS_DIV_BASE;
        end
        if (run_clock_config.auto_gate) begin
          next_gate = {deep_sleep_gating_set[2], deep_sleep_gating_set[1],
                       deep_sleep_gating_set[0]};
        end
      end
      plc_pkg::PM_RESTORE: begin
        next_gate = {deep_sleep_gating_set[2], deep_sleep_gating_set[1],
                     deep_sleep_gating_set[0]};
        if (!run_clock_config.auto_gate) begin
          next_gate = {run_gating_set[2], run_gating_set[1],
                       run_gating_set[0]};
        end
      end
      default: begin
      end
    endcase
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_clk_sel <= '0;
      o_core_clk_en <= 1'b1;
      o_mem_clk_en <= 1'b1;
      o_periph_clk_en <= 96'h0;
      o_pll_pwr_en <= 1'b0;
      o_pll_translation <= plc_pkg::XLAT_RST;
      o_main_osc_en <= 1'b1;
      o_int_osc_en <= 1'b1;
      o_pll_lock_irq <= 1'b0;
    end else begin
      o_clk_sel <= next_sel;
      o_core_clk_en <= (state == plc_pkg::PM_RUN);
      o_mem_clk_en <= (state == plc_pkg::PM_RUN);
      o_periph_clk_en <= next_gate;
      o_pll_pwr_en <= pll_on;
      o_pll_translation <= pll_translation_reg;
      o_main_osc_en <= !(state == plc_pkg::PM_DEEP
                         && ds_src != plc_pkg::SRC_MAIN);
      o_int_osc_en <= (state == plc_pkg::PM_DEEP) ? (ds_src != plc_pkg::SRC_MAIN)
                                                   : (eff_src != plc_pkg::SRC_MAIN);
      o_pll_lock_irq <= pll_lock_raw_flag && lock_int_mask;
    end
  end

endmodule

// file: plc_core_model.sv
// Partner model: processor core requests and main oscillator pin
module plc_core_model (
  // Clock and oscillator power
  input wire logic i_clk,
  input wire logic i_osc_en,
  // Pins towards the clock control
  output logic o_osc,
  output logic o_wfi,
  output logic o_deep_en,
  output logic o_wake
);
  // ==========================================================
  // Oscillator
  logic [1:0] div = 2'h0;
  initial begin
    o_osc = 1'b0;
    o_wfi = 1'b0;
    o_deep_en = 1'b0;
    o_wake = 1'b0;
  end
  // Stands still while unpowered, no stale toggling
  // Plain always: the initial block above also sets o_osc
  always @(posedge i_clk) begin
    if (!i_osc_en) begin
      div <= 2'h0;
      o_osc <= 1'b0;
    end else if (div == 2'h2) begin
      div <= 2'h0;
      o_osc <= ~o_osc;
    end else begin
      div <= div + 2'h1;
    end
  end
  // ==========================================================
  // Core requests
  task automatic sleep(input logic deep);
    @(posedge i_clk);
    o_deep_en <= deep;
    @(posedge i_clk);
    o_wfi <= 1'b1;
    @(posedge i_clk);
    o_wfi <= 1'b0;
  endtask
  task automatic wake;
    @(posedge i_clk);
    o_wake <= 1'b1;
    @(posedge i_clk);
    o_wake <= 1'b0;
  endtask
endmodule

// file: plc_clock_ctrl_properties.sv
// Checker: timing relations at the clock control ports
module plc_clock_ctrl_properties #(
  parameter logic [12:0] RELOCK_COUNT = plc_pkg::RELOCK_LOAD
) (
  // Clock, reset and requests
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic i_wait_for_interrupt_instr,
  input wire logic i_deep_sleep_en,
  // Clock tree controls
  input wire plc_pkg::plc_clk_sel_t o_clk_sel,
  input wire logic o_core_clk_en,
  input wire logic o_mem_clk_en,
  input wire logic o_pll_pwr_en,
  input wire logic o_pll_lock_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ==========================================================
  // Sequences
  // Eight cycles is safe: each count step spans several clocks
  sequence relock_quiet;
    (!o_pll_lock_irq && !o_clk_sel.use_pll) [*8];
  endsequence
  sequence run_wait;
    i_wait_for_interrupt_instr && o_core_clk_en;
  endsequence
  // ==========================================================
  // Assertions
  chk_mem_core_pair: assert property (o_mem_clk_en == o_core_clk_en)
    else $error("memory clock enable differs from core enable");
  chk_sleep_keeps_clk: assert property (run_wait ##0 !i_deep_sleep_en |->
    ##2 (!o_core_clk_en && o_clk_sel == $past(o_clk_sel, 2)))
    else $error("sleep entry wrong");
  chk_deep_pll_off: assert property (run_wait ##0 i_deep_sleep_en |->
    ##2 (!o_core_clk_en && !o_pll_pwr_en))
    else $error("deep sleep entry wrong");
  chk_deep_div_force: assert property (
    run_wait ##0 (i_deep_sleep_en && o_clk_sel.use_pll) |->
    ##2 (o_clk_sel.system_divider == 6'h0F ||
    o_clk_sel.system_divider == 6'h3F))
    else $error("deep sleep divider not forced");
  chk_pll_on_cause: assert property ($rose(o_pll_pwr_en) |->
    $past(i_wr, 2) || !o_core_clk_en)
    else $error("pll powered without cause");
  chk_sel_needs_pwr: assert property (o_clk_sel.use_pll |-> o_pll_pwr_en)
    else $error("pll selected while powered down");
  chk_relock_hold: assert property ($rose(o_pll_pwr_en) |-> relock_quiet)
    else $error("pll used or locked too early");
  chk_wake_sel_first: assert property ($rose(o_core_clk_en) |->
    o_clk_sel == $past(o_clk_sel))
    else $error("core clock enabled before selection settled");
endmodule

bind plc_clock_ctrl plc_clock_ctrl_properties #(
  .RELOCK_COUNT(RELOCK_COUNT)
) u_props (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_wr(i_wr),
  .i_wait_for_interrupt_instr(i_wait_for_interrupt_instr),
  .i_deep_sleep_en(i_deep_sleep_en),
  .o_clk_sel(o_clk_sel),
  .o_core_clk_en(o_core_clk_en),
  .o_mem_clk_en(o_mem_clk_en),
  .o_pll_pwr_en(o_pll_pwr_en),
  .o_pll_lock_irq(o_pll_lock_irq)
);

// file: plc_clock_ctrl_tb_top.sv
// Testbench: registers, relock, power modes and reset of clock control
module plc_clock_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
  } plc_row_t;
  localparam logic [95:0] RUN_G = {64'h0, 32'hA5A5_A5A5};
  localparam logic [95:0] SLP_G = {32'h0, 32'h5A5A_5A5A, 32'h0};
  localparam logic [95:0] DS_G = {32'h0F0F_1234, 64'h0};
  localparam logic [9:0] SEL_PLL = {plc_pkg::SRC_MAIN, 8'hC3};
  logic i_clk, i_rst, i_wr, i_rd;
  logic [11:0] i_addr;
  logic [31:0] i_wdata, o_rdata, o_pll_translation, d;
  logic wait_for_interrupt_instr, deep_en, wake, osc, o_core_clk_en, o_mem_clk_en;
  logic o_pll_pwr_en, o_main_osc_en, o_int_osc_en, o_pll_lock_irq;
  logic [95:0] o_periph_clk_en;
  plc_pkg::plc_clk_sel_t o_clk_sel;
  int miscompares = 0;
  int tests_run = 0;
  plc_row_t rows [10];
  plc_row_t rst_rows [6];
  // ==========================================================
  // Design and partner
  plc_clock_ctrl #(.RELOCK_COUNT(13'h0008)) DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_wait_for_interrupt_instr(wait_for_interrupt_instr), .i_deep_sleep_en(deep_en),
    .i_wake_irq(wake), .i_main_oscillator(osc), .o_clk_sel(o_clk_sel),
    .o_core_clk_en(o_core_clk_en), .o_mem_clk_en(o_mem_clk_en),
    .o_periph_clk_en(o_periph_clk_en), .o_pll_pwr_en(o_pll_pwr_en),
    .o_pll_translation(o_pll_translation), .o_main_osc_en(o_main_osc_en),
    .o_int_osc_en(o_int_osc_en), .o_pll_lock_irq(o_pll_lock_irq));
  plc_core_model u_core (.i_clk(i_clk), .i_osc_en(o_main_osc_en),
    .o_osc(osc), .o_wfi(wait_for_interrupt_instr), .o_deep_en(deep_en), .o_wake(wake));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // ==========================================================
  // Tasks
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [95:0] s, input logic [95:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %0h want %0h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic hang(input logic ok, inout int n);
    n++;
    if (!ok && n > 600) begin
      miscompares++;
      $display("unexpected at %0t: wait ran out", $time);
      end_of_test();
    end
  endtask
  task automatic wait_lock;
    int n;
    n = 0;
    rd(plc_pkg::OFS_RAW_INT_STATUS);
    while (d[0] !== 1'b1) begin
      hang(1'b0, n);
      rd(plc_pkg::OFS_RAW_INT_STATUS);
    end
  endtask
  task automatic wait_core;
    int n;
    n = 0;
    while (o_core_clk_en !== 1'b1) begin
      hang(1'b0, n);
      cyc(1);
    end
  endtask
  function automatic logic [31:0] cfg(input logic ag, input logic byp,
    input logic [4:0] x);
    return {4'h0, ag, 4'h3, 1'b1, 10'h000, byp, x, 6'h00};
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 12'h000;
    i_wdata = 32'h0000_0000;
    rows = '{
      '{plc_pkg::OFS_RUN_CFG, 32'hFFFF_FFFF, plc_pkg::RUN_CFG_MASK},
      '{plc_pkg::OFS_RUN_CFG_EXT, 32'hFFFF_FFFF, plc_pkg::RUN_CFG_EXT_MASK},
      '{plc_pkg::OFS_DS_CLK_CFG, 32'hFFFF_FFFF, plc_pkg::DS_CLK_CFG_MASK},
      '{12'h100, 32'hA5A5_A5A5, 32'hA5A5_A5A5},
      '{12'h114, 32'h5A5A_5A5A, 32'h5A5A_5A5A},
      '{12'h128, 32'h0F0F_1234, 32'h0F0F_1234},
      '{plc_pkg::OFS_INT_MASK, 32'hFFFF_FFFF, 32'h0000_0001},
      '{plc_pkg::OFS_RAW_INT_STATUS, 32'hFFFF_FFFF, 32'h0000_0000},
      '{plc_pkg::OFS_PLL_XLAT, 32'h0000_0000, 32'h0007_C0A9},
      '{12'h0FC, 32'hFFFF_FFFF, 32'h0000_0000}};
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    cyc(1);
    chk(o_clk_sel, {plc_pkg::SRC_INT, 8'h00});
    chk(o_pll_pwr_en, 1'b0);
    foreach (rows[k]) begin
      wr(rows[k].addr, rows[k].wdata);
      rd(rows[k].addr);
      chk(d, rows[k].rdata);
    end
    $display("register table done");
    // Change sequence through bypass, then lock polling
    wr(plc_pkg::OFS_RUN_CFG_EXT, 32'h0000_2810);
    wr(plc_pkg::OFS_RUN_CFG, 32'h0000_2800);
    wr(plc_pkg::OFS_RUN_CFG, 32'h0000_0940);
    wr(plc_pkg::OFS_RUN_CFG, cfg(1'b0, 1'b1, 5'h05));
    rd(plc_pkg::OFS_RAW_INT_STATUS);
    chk(d, 32'h0);
    chk(o_pll_pwr_en, 1'b1);
    chk(o_clk_sel, {plc_pkg::SRC_MAIN, 8'h03});
    wait_lock();
    cyc(2);
    chk(o_pll_lock_irq, 1'b1);
    wr(plc_pkg::OFS_RUN_CFG, cfg(1'b0, 1'b0, 5'h05));
    cyc(2);
    chk(o_clk_sel, SEL_PLL);
    wr(plc_pkg::OFS_RUN_CFG, cfg(1'b0, 1'b0, 5'h05));
    rd(plc_pkg::OFS_RAW_INT_STATUS);
    chk(d, 32'h1);
    wr(plc_pkg::OFS_RUN_CFG, cfg(1'b0, 1'b0, 5'h06));
    rd(plc_pkg::OFS_RAW_INT_STATUS);
    chk(d, 32'h0);
    chk(o_clk_sel.use_pll, 1'b0);
    rd(plc_pkg::OFS_PLL_XLAT);
    chk(d, {13'h0, 5'h06, plc_pkg::XLAT_F_BASE - 14'h0006});
    chk(o_pll_translation, d);
    wait_lock();
    cyc(2);
    chk(o_clk_sel, SEL_PLL);
    wr(plc_pkg::OFS_INT_MASK, 32'h0);
    cyc(3);
    chk(o_pll_lock_irq, 1'b0);
    $display("relock done");
    // Sleep with and without automatic gating
    chk(o_periph_clk_en, RUN_G);
    for (int ag = 0; ag < 2; ag++) begin
      wr(plc_pkg::OFS_RUN_CFG, cfg(ag[0], 1'b0, 5'h06));
      u_core.sleep(1'b0);
      cyc(3);
      chk(o_core_clk_en, 1'b0);
      chk(o_periph_clk_en, ag ? SLP_G : RUN_G);
      chk(o_clk_sel, SEL_PLL);
      u_core.wake();
      wait_core();
    end
    $display("sleep done");
    // Deep sleep on internal source while the pll runs
    wr(plc_pkg::OFS_DS_CLK_CFG, 32'h0000_0010);
    u_core.sleep(1'b1);
    cyc(3);
    chk(o_pll_pwr_en, 1'b0);
    chk(o_clk_sel.system_divider, 6'h0F);
    chk(o_clk_sel.oscillator_source, plc_pkg::SRC_INT);
    chk({o_main_osc_en, o_int_osc_en}, 2'b01);
    chk(o_periph_clk_en, DS_G);
    u_core.wake();
    wait_core();
    chk(o_clk_sel, SEL_PLL);
    $display("deep sleep done");
    // Extended fields only while selected
    wr(plc_pkg::OFS_RUN_CFG_EXT, 32'h8000_0820);
    cyc(2);
    chk(o_clk_sel.oscillator_source, plc_pkg::SRC_INT_DIV4);
    chk(o_clk_sel.use_pll, 1'b0);
    wr(plc_pkg::OFS_RUN_CFG_EXT, 32'h0000_2810);
    cyc(2);
    chk(o_clk_sel, SEL_PLL);
    $display("extended config done");
    // Second reset in mid-run
    rst_rows = '{
      '{plc_pkg::OFS_RUN_CFG, 32'h0, plc_pkg::RUN_CFG_RST},
      '{plc_pkg::OFS_RUN_CFG_EXT, 32'h0, plc_pkg::RUN_CFG_EXT_RST},
      '{plc_pkg::OFS_DS_CLK_CFG, 32'h0, plc_pkg::DS_CLK_CFG_RST},
      '{12'h100, 32'h0, plc_pkg::GATE_RST},
      '{plc_pkg::OFS_INT_MASK, 32'h0, 32'h0},
      '{plc_pkg::OFS_RAW_INT_STATUS, 32'h0, 32'h0}};
    @(posedge i_clk);
    i_rst <= 1'b1;
    cyc(2);
    chk({o_pll_pwr_en, o_core_clk_en, o_pll_lock_irq}, 3'b010);
    chk(o_periph_clk_en, 96'h0);
    @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (rst_rows[k]) begin
      rd(rst_rows[k].addr);
      chk(d, rst_rows[k].rdata);
    end
    $display("reset done");
    end_of_test();
  end
endmodule
